// ===== design/xcvr_pkg.sv
package xcvr_pkg;

  // Data path and bus widths
  localparam int DATA_W  = 8;
  localparam int COUNT_W = 8;
  localparam int APB_AW  = 12;
  localparam int APB_DW  = 32;

  // Register byte addresses
  localparam logic [APB_AW-1:0] CTRL_OFS    = 12'h000;
  localparam logic [APB_AW-1:0] STATUS_OFS  = 12'h004;
  localparam logic [APB_AW-1:0] STORE_A_OFS = 12'h008;
  localparam logic [APB_AW-1:0] STORE_B_OFS = 12'h00c;

  // Control register layout
  localparam int CTRL_W          = 4;
  localparam int CTRL_OE_N_BIT   = 0;
  localparam int CTRL_DIR_BIT    = 1;
  localparam int CTRL_B_SEL_BIT  = 2;
  localparam int CTRL_A_SEL_BIT  = 3;
  localparam logic [CTRL_W-1:0] CTRL_RESET = 4'h1;

  // Status register layout
  localparam int STAT_MODE_LSB = 0;
  localparam int STAT_MODE_MSB = 2;
  localparam int STAT_CLKA_BIT = 3;
  localparam int STAT_CLKB_BIT = 4;
  localparam int STAT_CNTA_LSB = 8;
  localparam int STAT_CNTB_LSB = 16;

  // Byte lane that carries the control field
  localparam int CTRL_LANE = 0;

  // Port drive modes, Gray coded along the usual path
  typedef enum logic [2:0] {
    MODE_ISOLATE   = 3'b000,
    MODE_A_LIVE    = 3'b001,
    MODE_A_STORED  = 3'b011,
    MODE_B_LIVE    = 3'b010,
    MODE_B_STORED  = 3'b110
  } mode_t;

endpackage : xcvr_pkg

// ===== design/pin_sync.sv
`timescale 1ns/1ns
`default_nettype none
module pin_sync
  import xcvr_pkg::*;
#(
  parameter int WIDTH = 1
) (
  input  wire logic             i_clk,   // System clock
  input  wire logic             i_rst_n, // Async reset, active low
  input  wire logic [WIDTH-1:0] i_pin,   // Raw pin level
  output logic      [WIDTH-1:0] o_level  // Filtered level
);

  logic [WIDTH-1:0] stage1;
  logic [WIDTH-1:0] stage2;
  logic [WIDTH-1:0] stage3;

  // Three-stage shift of the raw pin
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      stage1 <= '0;
      stage2 <= '0;
      stage3 <= '0;
    end else begin
      stage1 <= i_pin;
      stage2 <= stage1;
      stage3 <= stage2;
    end
  end

  // Each bit moves only once stages two and three agree
  for (genvar g = 0; g < WIDTH; g++) begin : g_bit
    always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
        o_level[g] <= 1'b0;
      end else if (stage2[g] == stage3[g]) begin
        o_level[g] <= stage3[g];
      end
    end
  end

endmodule : pin_sync
`default_nettype wire

// ===== design/capture_reg.sv
`timescale 1ns/1ns
`default_nettype none
module capture_reg
  import xcvr_pkg::*;
#(
  parameter int WIDTH = DATA_W
) (
  input  wire logic             i_clk,   // System clock
  input  wire logic             i_rst_n, // Async reset, active low
  input  wire logic             i_load,  // Capture edge seen
  input  wire logic [WIDTH-1:0] i_word,  // Word at the port
  output logic      [WIDTH-1:0] o_word   // Stored word
);

  // Load on the capture event, otherwise hold
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_word <= '0;
    end else if (i_load) begin
      o_word <= i_word;
    end
  end

endmodule : capture_reg
`default_nettype wire

// ===== design/registered_octal_bus_transceiver.sv
// The placing of the registers and register access over APB were chosen for this implementation.
`timescale 1ns/1ns
`default_nettype none
module registered_octal_bus_transceiver
  import xcvr_pkg::*;
#(
  parameter int WIDTH = DATA_W,
  parameter int CNT_W = COUNT_W
) (
  input  wire logic              i_clk,                  // System clock, 100 MHz
  input  wire logic              i_rst_n,                // Async reset, active low
  input  wire logic              i_psel,                 // APB select
  input  wire logic              i_penable,              // APB enable
  input  wire logic              i_pwrite,               // APB write
  input  wire logic [APB_AW-1:0] i_paddr,                // APB byte address
  input  wire logic [APB_DW-1:0] i_pwdata,               // APB write data
  input  wire logic [3:0]        i_pstrb,                // APB byte strobes
  output logic      [APB_DW-1:0] o_prdata,               // APB read data
  output logic                   o_pready,               // APB ready
  output logic                   o_pslverr,              // APB error
  input  wire logic              i_a_to_b_capture_clock, // Stores port A
  input  wire logic              i_b_to_a_capture_clock, // Stores port B
  input  wire logic [WIDTH-1:0]  i_port_a_bus,           // Port A pin level
  output logic      [WIDTH-1:0]  o_port_a_bus,           // Port A drive value
  output logic                   o_port_a_bus_oe,        // Port A driven
  input  wire logic [WIDTH-1:0]  i_port_b_bus,           // Port B pin level
  output logic      [WIDTH-1:0]  o_port_b_bus,           // Port B drive value
  output logic                   o_port_b_bus_oe         // Port B driven
);

  logic              clk_a_level;
  logic              clk_b_level;
  logic              clk_a_prev;
  logic              clk_b_prev;
  logic              a_rise;
  logic              b_rise;
  logic [WIDTH-1:0]  live_a;
  logic [WIDTH-1:0]  live_b;
  logic [WIDTH-1:0]  store_a;
  logic [WIDTH-1:0]  store_b;
  logic [CNT_W-1:0]  cnt_a;
  logic [CNT_W-1:0]  cnt_b;
  logic [CTRL_W-1:0] ctrl;
  logic              ctrl_oe_n;
  logic              ctrl_dir;
  logic              ctrl_b_output_source_select;
  logic              ctrl_a_output_source_select;
  mode_t             mode;
  mode_t             next_mode;
  logic              apb_setup;
  logic              apb_access;
  logic              addr_hit;
  logic              decode_err;
  logic [APB_DW-1:0] next_prdata;
  logic [APB_DW-1:0] status_word;

  // Pin synchronisers for both capture clocks and both buses
  pin_sync #(.WIDTH(1)) u_sync_clk_a (
    .i_clk   (i_clk),
    .i_rst_n (i_rst_n),
    .i_pin   (i_a_to_b_capture_clock),
    .o_level (clk_a_level)
  );

  pin_sync #(.WIDTH(1)) u_sync_clk_b (
    .i_clk   (i_clk),
    .i_rst_n (i_rst_n),
    .i_pin   (i_b_to_a_capture_clock),
    .o_level (clk_b_level)
  );

  pin_sync #(.WIDTH(WIDTH)) u_sync_bus_a (
    .i_clk   (i_clk),
    .i_rst_n (i_rst_n),
    .i_pin   (i_port_a_bus),
    .o_level (live_a)
  );

  pin_sync #(.WIDTH(WIDTH)) u_sync_bus_b (
    .i_clk   (i_clk),
    .i_rst_n (i_rst_n),
    .i_pin   (i_port_b_bus),
    .o_level (live_b)
  );

  // Previous filtered clock levels for edge detection
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      clk_a_prev <= 1'b0;
      clk_b_prev <= 1'b0;
    end else begin
      clk_a_prev <= clk_a_level;
      clk_b_prev <= clk_b_level;
    end
  end

  // Rising edges, independent of enable, direction and selects
  assign a_rise = clk_a_level && !clk_a_prev;
  assign b_rise = clk_b_level && !clk_b_prev;

  // A-side storage, loaded from the port A pins
  capture_reg #(.WIDTH(WIDTH)) u_store_a (
    .i_clk   (i_clk),
    .i_rst_n (i_rst_n),
    .i_load  (a_rise),
    .i_word  (live_a),
    .o_word  (store_a)
  );

  // B-side storage, loaded from the port B pins
  capture_reg #(.WIDTH(WIDTH)) u_store_b (
    .i_clk   (i_clk),
    .i_rst_n (i_rst_n),
    .i_load  (b_rise),
    .i_word  (live_b),
    .o_word  (store_b)
  );

  // Capture event counters, wrap around
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cnt_a <= '0;
      cnt_b <= '0;
    end else begin
      if (a_rise) begin
        cnt_a <= cnt_a + CNT_W'(1);
      end
      if (b_rise) begin
        cnt_b <= cnt_b + CNT_W'(1);
      end
    end
  end

  // Control fields
  assign ctrl_oe_n                   = ctrl[CTRL_OE_N_BIT];
  assign ctrl_dir                    = ctrl[CTRL_DIR_BIT];
  assign ctrl_b_output_source_select = ctrl[CTRL_B_SEL_BIT];
  assign ctrl_a_output_source_select = ctrl[CTRL_A_SEL_BIT];

  // Drive mode from enable, direction and selects
  always_comb begin
    if (ctrl_oe_n) begin
      next_mode = MODE_ISOLATE;
    end else if (!ctrl_dir) begin
      next_mode = ctrl_a_output_source_select ? MODE_A_STORED : MODE_A_LIVE;
    end else begin
      next_mode = ctrl_b_output_source_select ? MODE_B_STORED : MODE_B_LIVE;
    end
  end

  // Mode register
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      mode <= MODE_ISOLATE;
    end else begin
      mode <= next_mode;
    end
  end

  // Port drivers; one mode enables at most one port
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_port_a_bus    <= '0;
      o_port_b_bus    <= '0;
      o_port_a_bus_oe <= 1'b0;
      o_port_b_bus_oe <= 1'b0;
    end else begin
      case (mode)
        MODE_A_LIVE: begin
          o_port_a_bus    <= live_b;
          o_port_b_bus    <= '0;
          o_port_a_bus_oe <= 1'b1;
          o_port_b_bus_oe <= 1'b0;
        end
        MODE_A_STORED: begin
          o_port_a_bus    <= store_b;
          o_port_b_bus    <= '0;
          o_port_a_bus_oe <= 1'b1;
          o_port_b_bus_oe <= 1'b0;
        end
        MODE_B_LIVE: begin
          o_port_a_bus    <= '0;
          o_port_b_bus    <= live_a;
          o_port_a_bus_oe <= 1'b0;
          o_port_b_bus_oe <= 1'b1;
        end
        MODE_B_STORED: begin
          o_port_a_bus    <= '0;
          o_port_b_bus    <= store_a;
          o_port_a_bus_oe <= 1'b0;
          o_port_b_bus_oe <= 1'b1;
        end
        default: begin
          o_port_a_bus    <= '0;
          o_port_b_bus    <= '0;
          o_port_a_bus_oe <= 1'b0;
          o_port_b_bus_oe <= 1'b0;
        end
      endcase
    end
  end

  // APB phases
  assign apb_setup  = i_psel && !i_penable;
  assign apb_access = i_psel && i_penable;
  assign o_pready   = apb_access;
  assign o_pslverr  = apb_access && decode_err;

  // Status word: mode, clock levels, capture counts
  always_comb begin
    status_word = '0;
    status_word[STAT_MODE_MSB:STAT_MODE_LSB] = mode;
    status_word[STAT_CLKA_BIT] = clk_a_level;
    status_word[STAT_CLKB_BIT] = clk_b_level;
    status_word[STAT_CNTA_LSB +: CNT_W] = cnt_a;
    status_word[STAT_CNTB_LSB +: CNT_W] = cnt_b;
  end

  // Address decode and read mux
  always_comb begin
    addr_hit    = 1'b1;
    next_prdata = '0;
    case (i_paddr)
      CTRL_OFS:    next_prdata = APB_DW'(ctrl);
      STATUS_OFS:  next_prdata = status_word;
      STORE_A_OFS: next_prdata = APB_DW'(store_a);
      STORE_B_OFS: next_prdata = APB_DW'(store_b);
      default: begin
        addr_hit    = 1'b0;
        next_prdata = '0;
      end
    endcase
  end

  // Read data and decode error latched in the setup cycle
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_prdata   <= '0;
      decode_err <= 1'b0;
    end else if (apb_setup) begin
      o_prdata   <= i_pwrite ? '0 : next_prdata;
      decode_err <= !addr_hit;
    end
  end

  // Control register write at the completing access edge
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ctrl <= CTRL_RESET;
    end else if (apb_access && i_pwrite && (i_paddr == CTRL_OFS) && i_pstrb[CTRL_LANE]) begin
      ctrl <= i_pwdata[CTRL_W-1:0];
    end
  end

  // Checks on the design's own behaviour
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);

  sequence s_edge_a;
    a_rise;
  endsequence

  sequence s_edge_b;
    b_rise;
  endsequence

  sequence s_both_edges;
    a_rise && b_rise;
  endsequence

  sequence s_isolated_two;
    ctrl_oe_n [*2];
  endsequence

  excl_drive_a: assert property (
    !(o_port_a_bus_oe && o_port_b_bus_oe))
    else $error("both ports driven");

  hiz_isolate_a: assert property (
    s_isolated_two |=> (!o_port_a_bus_oe && !o_port_b_bus_oe))
    else $error("port driven while disabled");

  dir_select_a: assert property (
    !$past(ctrl_oe_n, 2) |->
      (o_port_a_bus_oe == !$past(ctrl_dir, 2)) && (o_port_b_bus_oe == $past(ctrl_dir, 2)))
    else $error("wrong port driven");

  a_live_path_a: assert property (
    (mode == MODE_A_LIVE) |=> (o_port_a_bus == $past(live_b)) && o_port_a_bus_oe)
    else $error("port A not carrying live B");

  a_stored_path_a: assert property (
    (mode == MODE_A_STORED) |=> (o_port_a_bus == $past(store_b)) && o_port_a_bus_oe)
    else $error("port A not carrying stored B");

  b_live_path_a: assert property (
    (mode == MODE_B_LIVE) |=> (o_port_b_bus == $past(live_a)) && o_port_b_bus_oe)
    else $error("port B not carrying live A");

  b_stored_path_a: assert property (
    (mode == MODE_B_STORED) |=> (o_port_b_bus == $past(store_a)) && o_port_b_bus_oe)
    else $error("port B not carrying stored A");

  capture_a_a: assert property (
    s_edge_a |=> (store_a == $past(live_a)))
    else $error("port A word not stored");

  capture_b_a: assert property (
    s_edge_b |=> (store_b == $past(live_b)))
    else $error("port B word not stored");

  coincident_store_a: assert property (
    (ctrl_oe_n ##0 s_both_edges) |=>
      (store_a == $past(live_a)) && (store_b == $past(live_b)))
    else $error("coincident capture lost");

  driven_store_a: assert property (
    (o_port_a_bus_oe ##0 s_edge_b) |=> (store_b == $past(live_b)))
    else $error("capture lost while A driven");

  hold_store_a: assert property (
    (!a_rise && !b_rise) |=> ($stable(store_a) && $stable(store_b)))
    else $error("stored word changed without edge");

  edge_count_a: assert property (
    s_edge_a |=> (cnt_a == $past(cnt_a) + CNT_W'(1)))
    else $error("capture count missed");

  apb_ready_a: assert property (
    apb_setup |=> (i_penable && i_psel) |-> o_pready)
    else $error("access phase not ready");

endmodule : registered_octal_bus_transceiver
`default_nettype wire

// ===== bench/bus_partner.sv
`timescale 1ns/1ns
`default_nettype none
module bus_partner
  import xcvr_pkg::*;
(
  input  wire logic [DATA_W-1:0] i_a_drive,  // Far-side word for port A
  input  wire logic [DATA_W-1:0] i_b_drive,  // Far-side word for port B
  input  wire logic [DATA_W-1:0] i_dev_a,    // Device drive value, port A
  input  wire logic              i_dev_a_oe, // Device drives port A
  input  wire logic [DATA_W-1:0] i_dev_b,    // Device drive value, port B
  input  wire logic              i_dev_b_oe, // Device drives port B
  output logic      [DATA_W-1:0] o_pin_a,    // Resolved port A level
  output logic      [DATA_W-1:0] o_pin_b     // Resolved port B level
);
  // Far side lets go of a port while the device drives it
  assign o_pin_a = i_dev_a_oe ? i_dev_a : i_a_drive;
  assign o_pin_b = i_dev_b_oe ? i_dev_b : i_b_drive;
endmodule : bus_partner
`default_nettype wire

// ===== bench/registered_octal_bus_transceiver_tb.sv
`timescale 1ns/1ns
`default_nettype none
module registered_octal_bus_transceiver_tb
  import xcvr_pkg::*;
;
  typedef struct {
    logic [3:0] ctrl;
    logic [2:0] mode;
    logic       a_oe;
    logic       b_oe;
    logic [7:0] pa;
    logic [7:0] pb;
  } row_t;
  logic              clk, rst_n, psel, penable, pwrite, pready, pslverr, err;
  logic [APB_AW-1:0] paddr;
  logic [3:0]        pstrb;
  logic [APB_DW-1:0] pwdata, prdata, rd;
  logic              clk_ab, clk_ba, dev_a_oe, dev_b_oe;
  logic [7:0]        a_drive, b_drive, pin_a, pin_b, dev_a, dev_b;
  int                n_mismatch, cmp_count;
  row_t              rows [6];

  registered_octal_bus_transceiver DUT (
    .i_clk(clk), .i_rst_n(rst_n), .i_psel(psel), .i_penable(penable),
    .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .i_pstrb(pstrb),
    .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr),
    .i_a_to_b_capture_clock(clk_ab), .i_b_to_a_capture_clock(clk_ba),
    .i_port_a_bus(pin_a), .o_port_a_bus(dev_a), .o_port_a_bus_oe(dev_a_oe),
    .i_port_b_bus(pin_b), .o_port_b_bus(dev_b), .o_port_b_bus_oe(dev_b_oe));

  bus_partner far_side (
    .i_a_drive(a_drive), .i_b_drive(b_drive), .i_dev_a(dev_a), .i_dev_a_oe(dev_a_oe),
    .i_dev_b(dev_b), .i_dev_b_oe(dev_b_oe), .o_pin_a(pin_a), .o_pin_b(pin_b));

  // Free-running system clock
  always #5 clk = ~clk;

  // Compare one value, count and report
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  // One APB transfer, held until pready is sampled high
  task automatic apb(input logic wr, input logic [APB_AW-1:0] addr,
                     input logic [APB_DW-1:0] wd, output logic [APB_DW-1:0] rdv,
                     output logic errv);
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= addr;
    pwdata  <= wd;
    @(posedge clk);
    penable <= 1'b1;
    // Only the hang guard ends a wait that never gets an answer
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rdv = prdata;
    errv = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // Set both far-side words, then pulse both capture clocks together
  task automatic capture(input logic [7:0] a, input logic [7:0] b);
    @(posedge clk);
    a_drive <= a;
    b_drive <= b;
    repeat (4) @(posedge clk);
    clk_ab <= 1'b1;
    clk_ba <= 1'b1;
    repeat (4) @(posedge clk);
    clk_ab <= 1'b0;
    clk_ba <= 1'b0;
    repeat (6) @(posedge clk);
  endtask : capture

  // Read one register and compare it
  task automatic rd_chk(input logic [APB_AW-1:0] addr, input logic [31:0] exp);
    apb(1'b0, addr, 32'h0, rd, err);
    chk(rd, exp);
  endtask : rd_chk

  // Verdict and end of run
  task automatic finish_test();
    $display("comparisons %0d, mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : finish_test

  // Both ports must never be driven together
  always @(posedge clk) begin
    if (rst_n === 1'b1) chk({31'h0, dev_a_oe & dev_b_oe}, 32'h0);
  end

  // Hang guard
  initial begin
    #100000;
    n_mismatch++;
    finish_test();
  end

  // Main sequence
  initial begin
    clk = 1'b0;
    rst_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
    pstrb = 4'hf;
    clk_ab = 1'b0;
    clk_ba = 1'b0;
    a_drive = 8'h00;
    b_drive = 8'h00;
    n_mismatch = 0;
    cmp_count = 0;
    rows = '{'{4'h1, 3'b000, 1'b0, 1'b0, 8'h3c, 8'h96},
             '{4'h0, 3'b001, 1'b1, 1'b0, 8'h96, 8'h96},
             '{4'h8, 3'b011, 1'b1, 1'b0, 8'hc3, 8'h96},
             '{4'h2, 3'b010, 1'b0, 1'b1, 8'h3c, 8'h3c},
             '{4'h6, 3'b110, 1'b0, 1'b1, 8'h3c, 8'h5a},
             '{4'hd, 3'b000, 1'b0, 1'b0, 8'h3c, 8'h96}};
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    // Reset state and an unmapped address
    rd_chk(CTRL_OFS, 32'h1);
    chk({30'h0, dev_a_oe, dev_b_oe}, 32'h0);
    rd_chk(12'h010, 32'h0);
    chk({31'h0, err}, 32'h1);
    // Control write without its byte lane is ignored
    @(posedge clk);
    pstrb <= 4'he;
    apb(1'b1, CTRL_OFS, 32'h0, rd, err);
    pstrb <= 4'hf;
    rd_chk(CTRL_OFS, 32'h1);
    chk({30'h0, dev_a_oe, dev_b_oe}, 32'h0);
    // Coincident captures while isolated
    capture(8'h5a, 8'hc3);
    rd_chk(STORE_A_OFS, 32'h5a);
    rd_chk(STORE_B_OFS, 32'hc3);
    @(posedge clk);
    a_drive <= 8'h3c;
    b_drive <= 8'h96;
    // Table of drive modes
    for (int i = 0; i < 6; i++) begin
      apb(1'b1, CTRL_OFS, {28'h0, rows[i].ctrl}, rd, err);
      repeat (8) @(posedge clk);
      apb(1'b0, STATUS_OFS, 32'h0, rd, err);
      chk({29'h0, rd[2:0]}, {29'h0, rows[i].mode});
      chk({30'h0, dev_a_oe, dev_b_oe}, {30'h0, rows[i].a_oe, rows[i].b_oe});
      chk({16'h0, pin_a, pin_b}, {16'h0, rows[i].pa, rows[i].pb});
    end
    // Capture while port A is driven with the stored B word
    apb(1'b1, CTRL_OFS, 32'h8, rd, err);
    repeat (4) @(posedge clk);
    capture(8'h11, 8'h77);
    rd_chk(STORE_A_OFS, 32'hc3);
    rd_chk(STORE_B_OFS, 32'h77);
    rd_chk(STATUS_OFS, 32'h0002_0203);
    // Port changes without a capture edge leave the stores alone
    @(posedge clk);
    a_drive <= 8'h01;
    b_drive <= 8'h02;
    repeat (10) @(posedge clk);
    rd_chk(STORE_A_OFS, 32'hc3);
    rd_chk(STORE_B_OFS, 32'h77);
    // Second reset in mid-run
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    rd_chk(CTRL_OFS, 32'h1);
    rd_chk(STORE_A_OFS, 32'h0);
    chk({30'h0, dev_a_oe, dev_b_oe}, 32'h0);
    finish_test();
  end
endmodule : registered_octal_bus_transceiver_tb
`default_nettype wire
